/* sac_clkdiv.sv */
/*
 * sac_clkdiv: conversion-clock tick generator.
 * assumes: divider value is stable or may change at any tick.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_clkdiv
   import sac_pkg::*;
#(
   parameter int DIV_W = SAC_DIV_W // divider field width
)(
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic [DIV_W-1:0] div_val,
   output var  logic             tick
);

   ////////////////////////////////////////////////////////////////////
   // elaboration check
   if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("sac_clkdiv: divider width out of range");
   end

   logic [DIV_W-1:0] cnt_reg;  // ticks count up to div_val, then back to zero
   logic [DIV_W-1:0] cnt_next;
   logic             tick_reg; // one system cycle per conv period
   logic             tick_next;

   ////////////////////////////////////////////////////////////////////
   // period of div_val plus one system clocks
   always_comb begin
      if (cnt_reg >= div_val) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next  = cnt_reg + DIV_W'(1);
         tick_next = 1'b0;
      end
   end

   // state registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule : sac_clkdiv
`default_nettype wire

/* sac_core_model.sv */
/* sac_core_model: stand-in for analog core, timers and start pin.
 * assumes: bench drives requests at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
   import sac_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       core_convert,
   input  wire sac_tmr_t   evt_req,
   input  wire logic       ext_req,
   output var  sac_tmr_t   tmr_evt,
   output var  logic       external_start_input,
   output var  logic [9:0] core_code
);
   // timer pulses and pin level come straight from the bench
   assign tmr_evt = evt_req;
   assign external_start_input = ext_req;
   // input drifts while idle, frozen while converting
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) core_code <= 10'h000;
      else if (!core_convert) core_code <= 10'($urandom);
   end
endmodule : sac_core_model
`default_nettype wire

/* sac_ctrl.sv */
/*
 * sac_ctrl: top of the converter control block. holds the control,
 * configuration and result registers behind the special-register
 * port, selects the start trigger, sequences tracking and conversion
 * and hands the finished code to the result bytes.
 * assumes: all inputs synchronous to ref_clk; the analog core presents
 * a stable code on core_code by the end of the conversion phase.
 * the divider runs free: the first tick after a trigger comes one to
 * divider-plus-one system cycles later.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
   import sac_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   // special-register port
   input  wire logic [7:0]            sfr_addr,
   input  wire logic                  sfr_wr,
   input  wire logic [7:0]            sfr_wdata,
   output var  logic [7:0]            sfr_rdata,
   // trigger sources
   input  wire sac_tmr_t              tmr_evt,
   input  wire logic                  external_start_input,
   // interrupt enable from the system interrupt controller
   input  wire logic                  conv_irq_enable,
   // analog core
   input  wire logic [SAC_CODE_W-1:0] core_code,
   output var  logic                  core_shutdown,
   output var  logic                  core_track,
   output var  logic                  core_convert,
   output var  logic                  core_gain_unity,
   output var  logic                  conv_irq_req
);

   ////////////////////////////////////////////////////////////////////
   // sequencer states
   typedef enum logic [1:0] {
      SAC_ST_IDLE,  // tracking or shut down
      SAC_ST_DELAY, // extra tracking before conversion
      SAC_ST_CONV   // successive approximation running
   } sac_state_t;

   // registered state, each but ext_prev_reg with its next value
   sac_state_t state_reg;     // sequencer state
   sac_state_t state_next;
   logic [3:0] cnt_reg;       // conversion-clock tick count
   logic [3:0] cnt_next;
   sac_cfg_t   cfg_reg;       // configuration register
   sac_cfg_t   cfg_next;
   logic       en_reg;        // converter enable
   logic       en_next;
   logic       dt_reg;        // delayed track enable
   logic       dt_next;
   logic       done_reg;      // conversion done flag
   logic       done_next;
   logic       busy_reg;      // conversion busy
   logic       busy_next;
   sac_src_t   src_reg;       // start source select
   sac_src_t   src_next;
   sac_res_t   res_reg;       // result byte pair
   sac_res_t   res_next;
   logic       ext_prev_reg;  // external start, last cycle
   logic [7:0] rdata_reg;     // read data
   logic [7:0] rdata_next;
   logic       track_reg;     // track output
   logic       track_next;
   logic       conv_reg;      // convert output
   logic       conv_next;
   logic       irq_reg;       // interrupt request
   logic       irq_next;
   logic       shut_reg;      // shutdown output
   logic       shut_next;

   // combinational helpers
   logic       tick;          // conversion-clock tick
   sac_res_t   fmt_res;       // formatted live code
   logic       wr_ctrl;       // write to control register
   logic       wr_cfg;        // write to configuration register
   logic       soft_start;    // one written to busy bit
   logic       trig;          // selected start event
   logic       ext_rise;      // rising edge of external start
   logic [3:0] conv_len;      // ticks per conversion
   logic       finish;        // last tick of conversion

   ////////////////////////////////////////////////////////////////////
   // conversion clock and result formatter
   sac_clkdiv #(
      .DIV_W   (SAC_DIV_W)
   ) u_clkdiv (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .div_val (cfg_reg.conv_clock_divider),
      .tick    (tick)
   );

   sac_format u_format (
      .code                  (core_code),
      .left_justify_select   (cfg_reg.left_justify_select),
      .eight_bit_mode_enable (cfg_reg.eight_bit_mode_enable),
      .res                   (fmt_res)
   );

   ////////////////////////////////////////////////////////////////////
   // register write decode
   // a write lands at the edge that samples the strobe
   assign wr_ctrl    = sfr_wr && (sfr_addr == SAC_ADDR_CTRL);
   assign wr_cfg     = sfr_wr && (sfr_addr == SAC_ADDR_CFG);
   // busy written as one is only a start request
   assign soft_start = wr_ctrl && sfr_wdata[SAC_CTRL_BUSY_BIT];
   // pin history resets low, the idle level, so no
   // false edge follows reset
   assign ext_rise   = external_start_input && !ext_prev_reg;

   ////////////////////////////////////////////////////////////////////
   // trigger selection
   // only the pin is edge-detected: a held pin
   // cannot start twice, but a held timer flag can
   always_comb begin
      // source as stored, not as being written
      unique case (src_reg)
         SAC_SRC_SOFT: trig = soft_start;
         SAC_SRC_TMR0: trig = tmr_evt.tmr0_ovf;
         SAC_SRC_TMR1: trig = tmr_evt.tmr1_ovf;
         SAC_SRC_TMR2: trig = tmr_evt.tmr2_split ?
                              tmr_evt.tmr2_lo_ovf : tmr_evt.tmr2_hi_ovf;
         SAC_SRC_TMR3: trig = tmr_evt.tmr3_split ?
                              tmr_evt.tmr3_lo_ovf : tmr_evt.tmr3_hi_ovf;
         SAC_SRC_EXT:  trig = ext_rise;
         default:      trig = 1'b0; // unused source codes
      endcase
   end

   // conversion length by mode
   // eight-bit mode skips the two lowest decisions
   assign conv_len = cfg_reg.eight_bit_mode_enable ?
                     SAC_TICKS_8 : SAC_TICKS_10;
   // last tick; a disabled converter never completes,
   // so an abort leaves done and the result alone
   assign finish   = en_reg && (state_reg == SAC_ST_CONV) && tick &&
                     (cnt_reg == conv_len - SAC_ONE);

   ////////////////////////////////////////////////////////////////////
   // sequencer and register file next values
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      cfg_next   = cfg_reg;
      en_next    = en_reg;
      dt_next    = dt_reg;
      src_next   = src_reg;
      done_next  = done_reg;
      res_next   = res_reg;
      // software writes
      // configuration takes the whole byte
      if (wr_cfg) begin
         cfg_next = sac_cfg_t'(sfr_wdata);
      end
      // control: busy is status only, bit 3 not stored
      if (wr_ctrl) begin
         en_next   = sfr_wdata[SAC_CTRL_EN_BIT];
         dt_next   = sfr_wdata[SAC_CTRL_DT_BIT];
         // done may be cleared or set by software
         done_next = sfr_wdata[SAC_CTRL_DONE_BIT];
         src_next  = sac_src_t'(sfr_wdata[SAC_CTRL_SRC_LSB +: SAC_SRC_W]);
      end
      // sequencer
      // triggers outside idle are ignored
      unique case (state_reg)
         // idle: enable must be set before the trigger
         SAC_ST_IDLE: begin
            if (en_reg && trig) begin
               cnt_next   = '0;
               state_next = dt_reg ? SAC_ST_DELAY
                                   : SAC_ST_CONV;
            end
         end
         // delay: sampler tracks three more ticks
         SAC_ST_DELAY: begin
            if (tick) begin
               cnt_next = cnt_reg + SAC_ONE;
               if (cnt_reg == SAC_TICKS_DLY - SAC_ONE) begin
                  cnt_next   = '0;
                  state_next = SAC_ST_CONV;
               end
            end
         end
         // conv: one bit decision per tick
         SAC_ST_CONV: begin
            if (tick) begin
               cnt_next = cnt_reg + SAC_ONE;
            end
            // last tick: result and done as busy falls;
            // after the write, so completion beats a clear
            if (finish) begin
               cnt_next   = '0;
               state_next = SAC_ST_IDLE;
               res_next   = fmt_res;
               done_next  = 1'b1;
            end
         end
      endcase
      // disabling aborts any conversion in flight
      // configuration, result and done survive it
      if (!en_reg) begin
         state_next = SAC_ST_IDLE;
         cnt_next   = '0;
      end
      // status follows the next state
      busy_next  = (state_next != SAC_ST_IDLE);
      conv_next  = (state_next == SAC_ST_CONV);
      // shutdown follows the enable bit
      shut_next  = !en_next;
      // tracking follows state and enable, and in idle the trigger source
      if (state_next == SAC_ST_CONV || !en_next) begin
         track_next = 1'b0;
      end else if (state_next == SAC_ST_DELAY) begin
         track_next = 1'b1;
      end else if (src_next == SAC_SRC_EXT) begin
         track_next = dt_next || !external_start_input;
      end else begin
         track_next = 1'b1;
      end
      // request stands while done and enable are set
      irq_next = done_next && conv_irq_enable;
   end

   ////////////////////////////////////////////////////////////////////
   // read data mux, registered
   // read data shows last cycle's address
   always_comb begin
      rdata_next = 8'h00; // unmapped addresses read zero
      unique case (sfr_addr)
         // control: bit 3 has no flag, reads zero
         SAC_ADDR_CTRL: begin
            rdata_next[SAC_CTRL_EN_BIT]   = en_reg;
            rdata_next[SAC_CTRL_DT_BIT]   = dt_reg;
            rdata_next[SAC_CTRL_DONE_BIT] = done_reg;
            rdata_next[SAC_CTRL_BUSY_BIT] = busy_reg;
            rdata_next[SAC_CTRL_SRC_LSB +: SAC_SRC_W] = src_reg;
         end
         // configuration and results read as stored
         SAC_ADDR_CFG:    rdata_next = cfg_reg;
         SAC_ADDR_RES_HI: rdata_next = res_reg.hi;
         SAC_ADDR_RES_LO: rdata_next = res_reg.lo;
         default:         rdata_next = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state registers
   // reset values are constants only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         // start shut down, idle, result cleared
         state_reg    <= SAC_ST_IDLE;
         cnt_reg      <= '0;
         cfg_reg      <= sac_cfg_t'(SAC_CFG_RESET);
         en_reg       <= SAC_CTRL_RESET[SAC_CTRL_EN_BIT];
         dt_reg       <= SAC_CTRL_RESET[SAC_CTRL_DT_BIT];
         done_reg     <= SAC_CTRL_RESET[SAC_CTRL_DONE_BIT];
         busy_reg     <= SAC_CTRL_RESET[SAC_CTRL_BUSY_BIT];
         src_reg      <= SAC_SRC_SOFT;
         res_reg      <= '0;
         ext_prev_reg <= 1'b0;
         rdata_reg    <= 8'h00;
         track_reg    <= 1'b0;
         conv_reg     <= 1'b0;
         irq_reg      <= 1'b0;
         shut_reg     <= 1'b1;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         cfg_reg      <= cfg_next;
         en_reg       <= en_next;
         dt_reg       <= dt_next;
         done_reg     <= done_next;
         busy_reg     <= busy_next;
         src_reg      <= src_next;
         res_reg      <= res_next;
         ext_prev_reg <= external_start_input;
         rdata_reg    <= rdata_next;
         track_reg    <= track_next;
         conv_reg     <= conv_next;
         irq_reg      <= irq_next;
         shut_reg     <= shut_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   // no gating between a register and its pin
   assign sfr_rdata       = rdata_reg;
   assign core_shutdown   = shut_reg;
   assign core_track      = track_reg;
   assign core_convert    = conv_reg;
   assign core_gain_unity = cfg_reg.gain_select;
   assign conv_irq_req    = irq_reg;

endmodule : sac_ctrl
`default_nettype wire

/* sac_ctrl_monitor.sv */
/* sac_ctrl_monitor: port checks for the converter control block.
 * assumes: bound onto sac_ctrl; one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_monitor
   import sac_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       conv_irq_enable,
   input wire logic       core_shutdown,
   input wire logic       core_track,
   input wire logic       core_convert,
   input wire logic       core_gain_unity,
   input wire logic       conv_irq_req
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic [8:0] run_reg;  // cycles of the running conversion
   logic [8:0] run_next;
   // count consecutive conversion cycles
   always_comb run_next = core_convert ? run_reg + 9'h001 : 9'h000;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) run_reg <= 9'h000;
      else run_reg <= run_next;
   end
   logic [7:0] wd_reg;   // write data of the last cycle
   always_ff @(posedge ref_clk) wd_reg <= sfr_wdata;

   ////////////////////////////////////////////////////////////////
   // config write taken at this edge
   sequence s_cfg_wr;
      sfr_wr && sfr_addr == SAC_ADDR_CFG;
   endsequence
   // conversion ended normally, not by shutdown
   sequence s_done;
      $fell(core_convert) && !core_shutdown;
   endsequence

   property p_off_idle;
      core_shutdown |=> !core_convert;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("conversion while shut down");
   property p_conv_min;
      s_done |-> run_reg >= 9'h00b;
   endproperty
   a_conv_min: assert property (p_conv_min)
      else $error("conversion too short");
   property p_conv_max;
      core_convert |-> run_reg < 9'h1a0;
   endproperty
   a_conv_max: assert property (p_conv_max)
      else $error("conversion too long");
   property p_trk_excl;
      !(core_track && core_convert);
   endproperty
   a_trk_excl: assert property (p_trk_excl)
      else $error("track and convert together");
   property p_irq_off;
      !conv_irq_enable |=> !conv_irq_req;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt while disabled");
   property p_gain;
      s_cfg_wr |=> core_gain_unity == wd_reg[0];
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain does not follow config");
   property p_busy_rd;
      sfr_addr == SAC_ADDR_CTRL && core_convert |=> sfr_rdata[4];
   endproperty
   a_busy_rd: assert property (p_busy_rd)
      else $error("busy low during conversion");
   property p_done_rd;
      s_done ##0 sfr_addr == SAC_ADDR_CTRL |=> sfr_rdata[5];
   endproperty
   a_done_rd: assert property (p_done_rd)
      else $error("done flag not set");
endmodule : sac_ctrl_monitor

bind sac_ctrl sac_ctrl_monitor u_sac_ctrl_monitor (
   .ref_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
   .conv_irq_enable, .core_shutdown, .core_track, .core_convert,
   .core_gain_unity, .conv_irq_req
);
`default_nettype wire

/* sac_format.sv */
/*
 * sac_format: places a raw code into the result byte pair.
 * assumes: purely combinational; caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_format
   import sac_pkg::*;
(
   input  wire logic [SAC_CODE_W-1:0] code,
   input  wire logic                  left_justify_select,
   input  wire logic                  eight_bit_mode_enable,
   output var  sac_res_t              res
);

   ////////////////////////////////////////////////////////////////////
   // justification and width selection
   always_comb begin
      res = '0;
      if (eight_bit_mode_enable) begin
         res.hi = code[SAC_CODE_W-1 -: 8];
         res.lo = 8'h00;
      end else if (left_justify_select) begin
         res.hi = code[SAC_CODE_W-1 -: 8];
         res.lo = {code[1:0], 6'h00};
      end else begin
         res.hi = {6'h00, code[SAC_CODE_W-1 -: 2]};
         res.lo = code[7:0];
      end
   end

endmodule : sac_format
`default_nettype wire

/* sac_pkg.sv */
/*
 * sac_pkg: constants, field layouts and carrier types for the
 * successive-approximation converter control block.
 * assumes: an 8-bit special-register port and a single system clock.
 */
package sac_pkg;

   ////////////////////////////////////////////////////////////////////
   // special-register addresses
   localparam logic [7:0] SAC_ADDR_CTRL   = 8'he8; // control register
   localparam logic [7:0] SAC_ADDR_RES_HI = 8'hbe; // result high byte
   localparam logic [7:0] SAC_ADDR_RES_LO = 8'hbd; // result low byte
   localparam logic [7:0] SAC_ADDR_CFG    = 8'hbc; // configuration

   ////////////////////////////////////////////////////////////////////
   // control register field positions
   localparam int SAC_CTRL_EN_BIT    = 7; // converter enable
   localparam int SAC_CTRL_DT_BIT    = 6; // delayed track enable
   localparam int SAC_CTRL_DONE_BIT  = 5; // conversion done flag
   localparam int SAC_CTRL_BUSY_BIT  = 4; // conversion busy
   localparam int SAC_CTRL_SRC_LSB   = 0; // start source select lsb
   localparam int SAC_SRC_W          = 3; // start source width

   // reset values
   localparam logic [7:0] SAC_CFG_RESET  = 8'hf8; // divider all ones
   localparam logic [7:0] SAC_CTRL_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////
   // timing in conversion-clock ticks
   localparam logic [3:0] SAC_TICKS_10  = 4'hd; // 13 ticks, 10-bit
   localparam logic [3:0] SAC_TICKS_8   = 4'hb; // 11 ticks, 8-bit
   localparam logic [3:0] SAC_TICKS_DLY = 4'h3; // delayed tracking
   localparam logic [3:0] SAC_ONE       = 4'h1;

   // code and divider widths
   localparam int SAC_CODE_W = 10; // result code width
   localparam int SAC_DIV_W  = 5;  // divider field width

   ////////////////////////////////////////////////////////////////////
   // start sources
   typedef enum logic [2:0] {
      SAC_SRC_SOFT  = 3'h0, // write of one to busy
      SAC_SRC_TMR0  = 3'h1,
      SAC_SRC_TMR2  = 3'h2,
      SAC_SRC_TMR1  = 3'h3,
      SAC_SRC_EXT   = 3'h4, // rising edge of external start
      SAC_SRC_TMR3  = 3'h5,
      SAC_SRC_NONE6 = 3'h6,
      SAC_SRC_NONE7 = 3'h7
   } sac_src_t;

   // configuration register layout
   typedef struct packed {
      logic [4:0] conv_clock_divider;    // bits 7:3
      logic       left_justify_select;   // bit 2
      logic       eight_bit_mode_enable; // bit 1
      logic       gain_select;           // bit 0, 1 = unity gain
   } sac_cfg_t;

   // timer overflow events, one-cycle pulses, and split-mode levels
   typedef struct packed {
      logic tmr0_ovf;    // timer 0 overflow
      logic tmr1_ovf;    // timer 1 overflow
      logic tmr2_lo_ovf; // timer 2 low byte overflow
      logic tmr2_hi_ovf; // timer 2 high byte overflow
      logic tmr2_split;  // timer 2 runs as 8-bit
      logic tmr3_lo_ovf;
      logic tmr3_hi_ovf;
      logic tmr3_split;
   } sac_tmr_t;

   // formatted result pair
   typedef struct packed {
      logic [7:0] hi; // result high byte
      logic [7:0] lo; // result low byte
   } sac_res_t;

endpackage : sac_pkg

/* test_sac_ctrl.sv */
/* test_sac_ctrl: self-checking bench for converter control.
 * assumes: package, design, core model and monitor compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_sac_ctrl
   import sac_pkg::*;
;
   logic       ref_clk = 1'b0;   // 200 MHz
   logic       nrst = 1'b0;      // active-low reset
   logic [7:0] sfr_addr = 8'h00; // register port
   logic       sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   sac_tmr_t   evt = '0;         // timer requests
   sac_tmr_t   tmr_evt;
   logic       ext_req = 1'b0;   // start pin request
   logic       ext_pin;
   logic       irq_en = 1'b0;    // interrupt enable
   logic [9:0] code;
   logic       shut, trk, cnv, gain, irq;
   int         fail_count = 0;
   int         total_checks = 0;

   always #2.5 ref_clk = ~ref_clk;

   sac_ctrl u_sac_ctrl (
      .ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .tmr_evt(tmr_evt), .external_start_input(ext_pin),
      .conv_irq_enable(irq_en), .core_code(code), .core_shutdown(shut),
      .core_track(trk), .core_convert(cnv), .core_gain_unity(gain),
      .conv_irq_req(irq)
   );
   sac_core_model u_sac_core_model (
      .ref_clk(ref_clk), .nrst(nrst), .core_convert(cnv), .evt_req(evt),
      .ext_req(ext_req), .tmr_evt(tmr_evt),
      .external_start_input(ext_pin), .core_code(code)
   );

   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      @(negedge ref_clk);
      d = sfr_rdata;
   endtask : rd
   // one-cycle timer overflow pulse
   task automatic fire(input sac_tmr_t m);
      @(negedge ref_clk);
      evt = sac_tmr_t'(evt | m);
      @(negedge ref_clk);
      evt = sac_tmr_t'(evt & ~m);
   endtask : fire
   function automatic sac_tmr_t ovf(input logic [2:0] s, input logic lo);
      sac_tmr_t m;
      m = '0;
      m.tmr0_ovf = (s == 3'h1);
      m.tmr1_ovf = (s == 3'h3);
      m.tmr2_lo_ovf = (s == 3'h2) && lo;
      m.tmr2_hi_ovf = (s == 3'h2) && !lo;
      m.tmr3_lo_ovf = (s == 3'h5) && lo;
      m.tmr3_hi_ovf = (s == 3'h5) && !lo;
      return m;
   endfunction : ovf
   // expected result byte pair
   function automatic logic [15:0] fmt(input logic [9:0] c,
                                       input logic lj, input logic eb);
      if (eb) return {c[9:2], 8'h00};
      if (lj) return {c, 6'h00};
      return {6'h00, c};
   endfunction : fmt

   // configure, trigger, time and check one conversion
   task automatic conv(input logic [2:0] src, input logic sp,
                       input logic dt, input logic lj, input logic eb,
                       input logic [4:0] d);
      logic [7:0] ctl, v, h;
      logic       g;
      logic [9:0] c;
      int         nt, nc, t, lo;
      g = 1'($urandom);
      ctl = {1'b1, dt, 3'b000, src};
      evt.tmr2_split = sp;
      evt.tmr3_split = sp;
      wr(SAC_ADDR_CFG, {d, lj, eb, g});
      wr(SAC_ADDR_CTRL, ctl);
      if (src == 3'h2 || src == 3'h5) fire(ovf(src, !sp));
      rd(SAC_ADDR_CFG, v);
      chk("cfg_read", {8'h00, d, lj, eb, g}, {8'h00, v});
      chk("gain", {15'h0, g}, {15'h0, gain});
      chk("idle_track", 16'h0001, {15'h0, trk});
      chk("awake", 16'h0000, {15'h0, shut});
      rd(SAC_ADDR_CTRL, v);
      chk("no_start", {8'h00, ctl}, {8'h00, v});
      if (src == 3'h0) wr(SAC_ADDR_CTRL, ctl | 8'h10);
      else if (src == 3'h4) begin
         @(negedge ref_clk);
         ext_req = 1'b1;
         @(negedge ref_clk);
      end
      else fire(ovf(src, sp));
      nt = 0;
      nc = 0;
      for (int i = 0; i < 600 && !(nc > 0 && cnv === 1'b0); i++) begin
         if (cnv === 1'b1) begin
            nc++;
            c = code;
         end
         else if (trk === 1'b1) nt++;
         @(negedge ref_clk);
      end
      if (nc == 0 || cnv !== 1'b0) begin
         fail_count++;
         $display("BAD conv_wait exp done got timeout");
         wrap_up();
      end
      lo = dt ? 2 * d + 3 : 0;
      chk("delay", 16'h0001,
          {15'h0, nt >= lo && nt <= (dt ? 3 * d + 3 : 0)});
      t = eb ? 11 : 13;
      lo = dt ? t * (d + 1) : (t - 1) * (d + 1) + 1;
      chk("conv_len", 16'h0001,
          {15'h0, nc >= lo && nc <= t * (d + 1)});
      chk("trk_after", {15'h0, (src == 3'h4) ? dt : 1'b1},
          {15'h0, trk});
      rd(SAC_ADDR_CTRL, v);
      chk("done_ctrl", {8'h00, ctl | 8'h20}, {8'h00, v});
      chk("irq", {15'h0, irq_en}, {15'h0, irq});
      rd(SAC_ADDR_RES_HI, h);
      rd(SAC_ADDR_RES_LO, v);
      chk("result", fmt(c, lj, eb), {h, v});
      ext_req = 1'b0;
   endtask : conv

   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      logic [7:0] ra [5];
      logic [7:0] re [5];
      ra = '{SAC_ADDR_CFG, SAC_ADDR_CTRL, SAC_ADDR_RES_HI,
             SAC_ADDR_RES_LO, 8'h55};
      re = '{SAC_CFG_RESET, SAC_CTRL_RESET, 8'h00, 8'h00, 8'h00};
      void'($urandom(61));
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      for (int k = 0; k < 5; k++) begin
         rd(ra[k], v);
         chk("reset_val", {8'h00, re[k]}, {8'h00, v});
      end
      chk("shutdown", 16'h0001, {15'h0, shut});
      // enable and start in one write must not start
      wr(SAC_ADDR_CFG, 8'h18);
      wr(SAC_ADDR_CTRL, 8'h90);
      repeat (4) @(negedge ref_clk);
      chk("off_start", 16'h0000, {15'h0, cnv});
      // start, then abort by clearing enable
      wr(SAC_ADDR_CTRL, 8'h90);
      repeat (4) @(negedge ref_clk);
      chk("run", 16'h0001, {15'h0, cnv});
      wr(SAC_ADDR_CTRL, 8'h00);
      repeat (60) @(negedge ref_clk);
      rd(SAC_ADDR_CTRL, v);
      chk("abort", 16'h0000, {8'h00, v});
      wr(SAC_ADDR_CTRL, 8'h86);
      fire(sac_tmr_t'(8'hff));
      chk("no_src", 16'h0000, {15'h0, cnv});
      // corners: fastest clock, slowest clock with delay
      conv(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
      conv(3'h4, 1'b0, 1'b1, 1'b1, 1'b0, 5'h1f);
      // every source, random modes, next trigger after done
      for (int k = 0; k < 24; k++) begin
         irq_en = 1'($urandom);
         conv(3'(k % 6), 1'($urandom), 1'($urandom), 1'($urandom),
              1'($urandom), 5'($urandom % 4));
      end
      wrap_up();
   end
endmodule : test_sac_ctrl
`default_nettype wire
